// file: bench/host_spi_model.sv
// Host controller model driving the four-wire serial register port
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
    input  wire logic        clk,
    output logic             csN,
    output logic             sclk,
    output logic             mosi,
    input  wire logic        miso,
    input  wire logic        misoOe,
    output logic             rdDone,
    output logic [15:0]      rdWord
);
    // Three clk per serial phase keeps the serial clock well under its 10 MHz ceiling
    localparam int HALF = 3;

    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        rdDone = 1'b0;
        rdWord = 16'h0000;
    end

    // ------------------------------------------------------------------
    // One framed transfer: 7-bit address, W/R bit, one 16-bit word
    // ------------------------------------------------------------------
    task automatic xfer(input logic [6:0] addr, input logic wr, input logic [15:0] data);
        logic [23:0] bits;
        bits = {addr, wr, data};
        @(negedge clk);
        csN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            mosi = bits[i];
            repeat (HALF) @(negedge clk);
            sclk = 1'b1;
            if (i < 16) begin
                rdWord[i] = misoOe ? miso : ~miso;
            end
            repeat (HALF) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        csN = 1'b1;
        // Deselected data line must not keep showing the last bit
        mosi = ~mosi;
        if (!wr) begin
            rdDone = 1'b1;
            @(negedge clk);
            rdDone = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the operating mode sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int TICKS = 4;
    logic clk, sysRst, csN, sclk, mosi, miso, misoOe, slotADone, slotBDone;
    logic fifoClear, sampleIrq, slotAToFifo, slotBToFifo, modeStuck, sampleTick, rdDone;
    logic [7:0]  fifoLevel;
    logic [1:0]  modeState;
    logic [2:0]  led1Slew, led2Slew, led3Slew;
    logic [2:0]  slew [3];
    logic [15:0] rdWord;
    logic [15:0] expQ [$];
    int          seed, nMismatch, totalChecks, clrCount, tickCount, cycles;

    operating_mode_sequencer #(.TICK_CYCLES(TICKS)) DUT (
        .clk(clk), .sys_rst(sysRst), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso),
        .misoOe(misoOe), .slotASampleDone(slotADone), .slotBSampleDone(slotBDone),
        .fifoLevel(fifoLevel), .fifoClear(fifoClear), .sampleIrq(sampleIrq),
        .slotAToFifo(slotAToFifo), .slotBToFifo(slotBToFifo), .modeState(modeState),
        .modeStuck(modeStuck), .sampleTick(sampleTick), .led1Slew(led1Slew),
        .led2Slew(led2Slew), .led3Slew(led3Slew)
    );
    host_spi_model HOST (
        .clk(clk), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso),
        .misoOe(misoOe), .rdDone(rdDone), .rdWord(rdWord)
    );

    always #10 clk = ~clk;

    // ------------------------------------------------------------------
    // Compare, access and closing tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] got);
        totalChecks++;
        if (got !== e) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", name, e, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        HOST.xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        expQ.push_back(e);
        HOST.xfer(a, 1'b0, 16'h0000);
    endtask
    task automatic waitMode(input logic [1:0] e);
        int n;
        n = 0;
        while (modeState !== e && n < 12 * TICKS) begin
            @(negedge clk);
            n++;
        end
        chk("mode state", {14'h0000, e}, {14'h0000, modeState});
    endtask
    task automatic holdMode(input logic [1:0] e);
        repeat (3 * TICKS) @(negedge clk);
        chk("mode state", {14'h0000, e}, {14'h0000, modeState});
    endtask
    task automatic pulseDone();
        slotADone = 1'b1;
        slotBDone = 1'b1;
        @(negedge clk);
        slotADone = 1'b0;
        slotBDone = 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Output watchers
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rdDone === 1'b1) chk("read word", expQ.pop_front(), rdWord);
        if (fifoClear === 1'b1) clrCount++;
        if (sampleTick === 1'b1) tickCount++;
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            summarize();
        end
    end

    initial begin
        clk = 1'b0;
        sysRst = 1'b1;
        slotADone = 1'b0;
        slotBDone = 1'b0;
        seed = 38;
        fifoLevel = 8'($random(seed));
        repeat (6) @(negedge clk);
        sysRst = 1'b0;
        chk("mode state", 16'h0000, {14'h0000, modeState});
        rd(op_mode_pkg::ADDR_MODE, 16'h0000);
        wr(op_mode_pkg::ADDR_MODE, op_mode_pkg::MODE_PROGRAM);
        holdMode(2'h0);
        chk("tick count", 16'h0000, 16'(tickCount));
        wr(op_mode_pkg::ADDR_CLK_CTRL, 16'h0080);
        waitMode(2'h1);
        chk("tick seen", 16'h0001, {15'h0000, tickCount != 0});
        $display("test startup done");
        for (int k = 0; k < 3; k++) begin
            slew[k] = 3'($random(seed));
            wr(7'(op_mode_pkg::ADDR_LED1 + k), {9'h000, slew[k], 4'h0});
        end
        chk("led1 slew", {13'h0000, slew[0]}, {13'h0000, led1Slew});
        chk("led2 slew", {13'h0000, slew[1]}, {13'h0000, led2Slew});
        chk("led3 slew", {13'h0000, slew[2]}, {13'h0000, led3Slew});
        rd(op_mode_pkg::ADDR_LED2, {9'h000, slew[1], 4'h0});
        wr(op_mode_pkg::ADDR_SLOT_ROUTE, 16'h0002);
        chk("slot route", 16'h0002, {14'h0000, slotBToFifo, slotAToFifo});
        wr(op_mode_pkg::ADDR_INT_MASK, 16'h0040);
        wr(op_mode_pkg::ADDR_MODE, 16'h0003);
        rd(op_mode_pkg::ADDR_MODE, 16'h0001);
        holdMode(2'h1);
        wr(op_mode_pkg::ADDR_MODE, op_mode_pkg::MODE_NORMAL);
        waitMode(2'h2);
        $display("test config done");
        pulseDone();
        rd(op_mode_pkg::ADDR_STATUS, {fifoLevel, 8'h60});
        chk("sample irq", 16'h0001, {15'h0000, sampleIrq});
        wr(op_mode_pkg::ADDR_STATUS, 16'h0020);
        rd(op_mode_pkg::ADDR_STATUS, {fifoLevel, 8'h40});
        chk("sample irq", 16'h0000, {15'h0000, sampleIrq});
        pulseDone();
        wr(op_mode_pkg::ADDR_MODE, op_mode_pkg::MODE_PROGRAM);
        waitMode(2'h1);
        wr(op_mode_pkg::ADDR_STATUS, 16'h00ff);
        rd(op_mode_pkg::ADDR_STATUS, {fifoLevel, 8'h00});
        chk("fifo clears", 16'h0000, 16'(clrCount));
        pulseDone();
        wr(op_mode_pkg::ADDR_STATUS, 16'h80ff);
        chk("fifo clears", 16'h0001, 16'(clrCount));
        rd(op_mode_pkg::ADDR_STATUS, {fifoLevel, 8'h00});
        chk("sample irq", 16'h0000, {15'h0000, sampleIrq});
        $display("test status done");
        wr(op_mode_pkg::ADDR_MODE, op_mode_pkg::MODE_STANDBY);
        waitMode(2'h0);
        wr(op_mode_pkg::ADDR_CLK_CTRL, 16'h0000);
        chk("stuck flag", 16'h0000, {15'h0000, modeStuck});
        wr(op_mode_pkg::ADDR_MODE, op_mode_pkg::MODE_PROGRAM);
        holdMode(2'h0);
        wr(op_mode_pkg::ADDR_CLK_CTRL, 16'h0080);
        waitMode(2'h1);
        // Clock enable dropped outside standby on purpose
        wr(op_mode_pkg::ADDR_CLK_CTRL, 16'h0000);
        wr(op_mode_pkg::ADDR_CLK_CTRL, 16'h0080);
        wr(op_mode_pkg::ADDR_MODE, op_mode_pkg::MODE_STANDBY);
        holdMode(2'h1);
        chk("stuck flag", 16'h0001, {15'h0000, modeStuck});
        $display("test stuck done");
        summarize();
    end
endmodule
`default_nettype wire

// file: hw/op_mode_pkg.sv
// Constants shared by the operating mode sequencer and its serial register port
// Operation
// [RULE_01] After reset the device is in standby and the mode register reads zero.
// [RULE_02] Setting bit 7 of clock control starts the 32 kHz sample clock.
// [RULE_03] With the sample clock stopped, the mode machine never changes state.
// [RULE_04] Writing 1 to the mode register moves the device to program mode.
// [RULE_05] Clock enable and program request may come in any order; transition needs both.
// [RULE_06] Host writes the other configuration registers in program mode, any order.
// [RULE_07] Writing 2 to the mode register starts normal sampling.
// [RULE_08] Host returns to program mode before configuring or entering standby.
// [RULE_09] Writing 0x00FF to status clears every pending interrupt flag.
// [RULE_10] Writing 0x80FF to status clears all flags and empties the FIFO.
// [RULE_11] Writing 0 to the mode register places the device in standby.
// [RULE_12] Host clears the sample clock enable only while in standby.
// [RULE_13] Clearing the clock enable outside standby leaves the device stuck for good.
// [RULE_14] Host should leave the sample clock running once started.
// [RULE_15] Each of three LED drivers has a slew field at bits 6 to 4.
// [RULE_16] Each time slot picks FIFO or data registers, with optional interrupt.
// [RULE_17] Writing one to status bit 15 empties the FIFO and resets its state.
// [RULE_18] Slot sample flags at status bits 5 and 6 clear on a written one.
// [RULE_19] Mode writes other than 0, 1 or 2 are ignored.
package op_mode_pkg;

    // ------------------------------------------------------------------
    // Register offsets (7-bit serial address)
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_STATUS     = 7'h00;
    localparam logic [6:0] ADDR_INT_MASK   = 7'h01;
    localparam logic [6:0] ADDR_MODE       = 7'h10;
    localparam logic [6:0] ADDR_SLOT_ROUTE = 7'h11;
    localparam logic [6:0] ADDR_LED1       = 7'h22;
    localparam logic [6:0] ADDR_LED2       = 7'h23;
    localparam logic [6:0] ADDR_LED3       = 7'h24;
    localparam logic [6:0] ADDR_CLK_CTRL   = 7'h4B;
    // Burst accesses do not advance past these
    localparam logic [6:0] ADDR_NOINC_A    = 7'h5F;
    localparam logic [6:0] ADDR_NOINC_B    = 7'h60;
    localparam logic [6:0] ADDR_NOINC_C    = 7'h7F;

    // ------------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------------
    localparam int         BIT_CLK_EN      = 7;
    localparam int         BIT_SLOTA_INT   = 5;
    localparam int         BIT_SLOTB_INT   = 6;
    localparam int         BIT_FIFO_CLEAR  = 15;
    localparam int         SLEW_LSB        = 4;
    localparam int         SLEW_MSB        = 6;
    localparam logic [15:0] MODE_STANDBY   = 16'h0000;
    localparam logic [15:0] MODE_PROGRAM   = 16'h0001;
    localparam logic [15:0] MODE_NORMAL    = 16'h0002;
    localparam logic [15:0] RST_ZERO       = 16'h0000;
    localparam logic [15:0] RST_INT_MASK   = 16'h0060;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ          = 50_000_000;
    localparam int SAMPLE_CLK_HZ       = 32_000;
    localparam int SAMPLE_TICK_CYCLES  = SYS_CLK_HZ / SAMPLE_CLK_HZ;

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_PROGRAM,
        ST_NORMAL
    } op_state_t;

endpackage

// file: hw/operating_mode_sequencer.sv
// Operating mode state machine, sample clock divider and control registers
`timescale 1ns/10ps
`default_nettype none
module operating_mode_sequencer #(
    parameter int TICK_CYCLES = op_mode_pkg::SAMPLE_TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        csN,
    input  wire logic        sclk,
    input  wire logic        mosi,
    output logic             miso,
    output logic             misoOe,
    input  wire logic        slotASampleDone,
    input  wire logic        slotBSampleDone,
    input  wire logic [7:0]  fifoLevel,
    output logic             fifoClear,
    output logic             sampleIrq,
    output logic             slotAToFifo,
    output logic             slotBToFifo,
    output logic [1:0]       modeState,
    output logic             modeStuck,
    output logic             sampleTick,
    output logic [2:0]       led1Slew,
    output logic [2:0]       led2Slew,
    output logic [2:0]       led3Slew
);
    localparam int CW = $clog2(TICK_CYCLES + 1);

    logic [6:0]  regAddr;
    logic        wrStrobe;
    logic        rdStrobe;
    logic [15:0] wrData;
    logic [15:0] rdData;
    logic [6:0]  wrAddr;

    logic [15:0] modeReg_q;
    logic [15:0] clkCtrl_q;
    logic [15:0] intMask_q;
    logic [15:0] slotRoute_q;
    logic [15:0] ledCtrl_q [3];
    logic [1:0]  intFlags_q;
    logic        stuck_q;
    logic [CW-1:0] divCnt_q;
    logic        tick_q;
    op_mode_pkg::op_state_t state_q;

    serial_reg_port u_port (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .csN      (csN),
        .sclk     (sclk),
        .mosi     (mosi),
        .miso     (miso),
        .misoOe   (misoOe),
        .regAddr  (regAddr),
        .wrStrobe (wrStrobe),
        .rdStrobe (rdStrobe),
        .wrData   (wrData),
        .rdData   (rdData)
    );

    function automatic logic [6:0] prevAddr(input logic [6:0] a);
        if (a == op_mode_pkg::ADDR_NOINC_A || a == op_mode_pkg::ADDR_NOINC_B
            || a == op_mode_pkg::ADDR_NOINC_C) begin
            prevAddr = a;
        end else begin
            prevAddr = a - 7'd1;
        end
    endfunction

    // Port advances its address with the strobe, so step back one
    assign wrAddr = prevAddr(regAddr);

    function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
        hit = wrStrobe && (a == target);
    endfunction

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            modeReg_q   <= op_mode_pkg::MODE_STANDBY;              // [RULE_01]
            clkCtrl_q   <= op_mode_pkg::RST_ZERO;
            intMask_q   <= op_mode_pkg::RST_INT_MASK;
            slotRoute_q <= op_mode_pkg::RST_ZERO;
        end else begin
            if (hit(wrAddr, op_mode_pkg::ADDR_MODE) &&
                (wrData == op_mode_pkg::MODE_STANDBY || wrData == op_mode_pkg::MODE_PROGRAM ||
                 wrData == op_mode_pkg::MODE_NORMAL)) begin
                modeReg_q <= wrData;                                // [RULE_19]
            end
            if (hit(wrAddr, op_mode_pkg::ADDR_CLK_CTRL)) begin
                clkCtrl_q <= wrData;                                // [RULE_02]
            end
            if (hit(wrAddr, op_mode_pkg::ADDR_INT_MASK)) begin
                intMask_q <= wrData;
            end
            if (hit(wrAddr, op_mode_pkg::ADDR_SLOT_ROUTE)) begin
                slotRoute_q <= wrData;                              // [RULE_16]
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gLed
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ledCtrl_q[g] <= op_mode_pkg::RST_ZERO;
                end else if (hit(wrAddr, op_mode_pkg::ADDR_LED1 + 7'(g))) begin
                    ledCtrl_q[g] <= wrData;                         // [RULE_15]
                end
            end
        end
    endgenerate

    assign led1Slew = ledCtrl_q[0][op_mode_pkg::SLEW_MSB:op_mode_pkg::SLEW_LSB];
    assign led2Slew = ledCtrl_q[1][op_mode_pkg::SLEW_MSB:op_mode_pkg::SLEW_LSB];
    assign led3Slew = ledCtrl_q[2][op_mode_pkg::SLEW_MSB:op_mode_pkg::SLEW_LSB];
    assign slotAToFifo = slotRoute_q[0];
    assign slotBToFifo = slotRoute_q[1];

    // ------------------------------------------------------------------
    // Sample clock divider, runs only while enabled
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_q <= '0;
            tick_q   <= 1'b0;
        end else if (!clkCtrl_q[op_mode_pkg::BIT_CLK_EN]) begin
            divCnt_q <= '0;
            tick_q   <= 1'b0;                                       // [RULE_03]
        end else if (divCnt_q == CW'(TICK_CYCLES - 1)) begin
            divCnt_q <= '0;
            tick_q   <= 1'b1;                                       // [RULE_02]
        end else begin
            divCnt_q <= divCnt_q + CW'(1);
            tick_q   <= 1'b0;
        end
    end

    assign sampleTick = tick_q;

    // ------------------------------------------------------------------
    // Mode state machine, stepped by the sample clock
    // ------------------------------------------------------------------
    // Clock dropped outside standby: no way back short of reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stuck_q <= 1'b0;
        end else if (state_q != op_mode_pkg::ST_STANDBY &&
                     !clkCtrl_q[op_mode_pkg::BIT_CLK_EN] && !stuck_q) begin
            stuck_q <= 1'b1;                                        // [RULE_13]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= op_mode_pkg::ST_STANDBY;                     // [RULE_01]
        end else if (tick_q && !stuck_q &&
                     clkCtrl_q[op_mode_pkg::BIT_CLK_EN]) begin      // [RULE_03] [RULE_05]
            case (modeReg_q[1:0])
                2'd0: begin
                    state_q <= op_mode_pkg::ST_STANDBY;             // [RULE_11]
                end
                2'd1: begin
                    state_q <= op_mode_pkg::ST_PROGRAM;             // [RULE_04]
                end
                2'd2: begin
                    state_q <= op_mode_pkg::ST_NORMAL;              // [RULE_07]
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    assign modeState = state_q;
    assign modeStuck = stuck_q;

    // ------------------------------------------------------------------
    // Status: slot sample flags, write-one-to-clear, set wins
    // ------------------------------------------------------------------
    logic statusWr;
    assign statusWr = hit(wrAddr, op_mode_pkg::ADDR_STATUS);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            intFlags_q <= 2'b00;
            fifoClear  <= 1'b0;
        end else begin
            intFlags_q[0] <= slotASampleDone |
                (intFlags_q[0] & ~(statusWr & wrData[op_mode_pkg::BIT_SLOTA_INT])); // [RULE_18]
            intFlags_q[1] <= slotBSampleDone |
                (intFlags_q[1] & ~(statusWr & wrData[op_mode_pkg::BIT_SLOTB_INT])); // [RULE_09]
            fifoClear <= statusWr & wrData[op_mode_pkg::BIT_FIFO_CLEAR];           // [RULE_10] [RULE_17]
        end
    end

    assign sampleIrq = |(intFlags_q & ~{intMask_q[op_mode_pkg::BIT_SLOTB_INT],
                                        intMask_q[op_mode_pkg::BIT_SLOTA_INT]});   // [RULE_16]

    // ------------------------------------------------------------------
    // Read mux; unmapped addresses read zero
    // ------------------------------------------------------------------
    always_comb begin
        case (regAddr)
            op_mode_pkg::ADDR_STATUS:     rdData = {fifoLevel, 1'b0, intFlags_q, 5'b0};
            op_mode_pkg::ADDR_INT_MASK:   rdData = intMask_q;
            op_mode_pkg::ADDR_MODE:       rdData = modeReg_q;
            op_mode_pkg::ADDR_SLOT_ROUTE: rdData = slotRoute_q;
            op_mode_pkg::ADDR_LED1:       rdData = ledCtrl_q[0];
            op_mode_pkg::ADDR_LED2:       rdData = ledCtrl_q[1];
            op_mode_pkg::ADDR_LED3:       rdData = ledCtrl_q[2];
            op_mode_pkg::ADDR_CLK_CTRL:   rdData = clkCtrl_q;
            default:                      rdData = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_clock_off_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_03]
        !clkCtrl_q[op_mode_pkg::BIT_CLK_EN] |=> $stable(state_q))
        else $error("mode changed with sample clock stopped");
    a_tick_period: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_02]
        tick_q |=> !tick_q)
        else $error("sample tick longer than one cycle");
    a_program_entry: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_04]
        tick_q && !stuck_q && clkCtrl_q[op_mode_pkg::BIT_CLK_EN] &&
        modeReg_q == op_mode_pkg::MODE_PROGRAM
        |=> state_q == op_mode_pkg::ST_PROGRAM)
        else $error("program mode not entered");
    a_normal_entry: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_07]
        tick_q && !stuck_q && clkCtrl_q[op_mode_pkg::BIT_CLK_EN] &&
        modeReg_q == op_mode_pkg::MODE_NORMAL
        |=> state_q == op_mode_pkg::ST_NORMAL)
        else $error("normal mode not entered");
    a_standby_entry: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_11]
        tick_q && !stuck_q && clkCtrl_q[op_mode_pkg::BIT_CLK_EN] &&
        modeReg_q == op_mode_pkg::MODE_STANDBY
        |=> state_q == op_mode_pkg::ST_STANDBY)
        else $error("standby not entered");
    a_stuck_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_13]
        stuck_q |=> stuck_q && $stable(state_q))
        else $error("stuck device changed mode");
    a_bad_mode: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_19]
        wrStrobe && wrAddr == op_mode_pkg::ADDR_MODE && wrData > op_mode_pkg::MODE_NORMAL
        |=> $stable(modeReg_q))
        else $error("illegal mode value stored");
    a_fifo_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_10]
        statusWr && wrData[op_mode_pkg::BIT_FIFO_CLEAR] |=> fifoClear)
        else $error("FIFO clear not issued");
    a_flag_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_18]
        statusWr && wrData[op_mode_pkg::BIT_SLOTA_INT] && !slotASampleDone |=> !intFlags_q[0])
        else $error("slot A flag not cleared");
    a_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_09]
        slotBSampleDone |=> intFlags_q[1])
        else $error("slot B event lost");
endmodule
`default_nettype wire

// file: hw/serial_reg_port.sv
// Four-wire serial slave: address byte then 16-bit words, MSB first
`timescale 1ns/10ps
`default_nettype none
module serial_reg_port (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        csN,
    input  wire logic        sclk,
    input  wire logic        mosi,
    output logic             miso,
    output logic             misoOe,
    output logic [6:0]       regAddr,
    output logic             wrStrobe,
    output logic             rdStrobe,
    output logic [15:0]      wrData,
    input  wire logic [15:0] rdData
);
    logic        sclkPrev_q;
    logic [4:0]  bitCnt_q;
    logic        inData_q;
    logic        isWrite_q;
    logic [15:0] rxShift_q;
    logic [15:0] txShift_q;
    logic        loadTx_q;
    logic        misoQ_q;
    logic        sclkRise;
    logic        sclkFall;

    function automatic logic noIncrement(input logic [6:0] a);
        noIncrement = (a == op_mode_pkg::ADDR_NOINC_A) || (a == op_mode_pkg::ADDR_NOINC_B)
                   || (a == op_mode_pkg::ADDR_NOINC_C);
    endfunction

    assign sclkRise = ~csN & sclk & ~sclkPrev_q;
    assign sclkFall = ~csN & ~sclk & sclkPrev_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclkPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= sclk;
        end
    end

    // ------------------------------------------------------------------
    // Receive framing and address handling
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bitCnt_q  <= 5'h0;
            inData_q  <= 1'b0;
            isWrite_q <= 1'b0;
            rxShift_q <= 16'h0000;
            regAddr   <= 7'h00;
            wrStrobe  <= 1'b0;
            wrData    <= 16'h0000;
            loadTx_q  <= 1'b0;
        end else begin
            wrStrobe <= 1'b0;
            loadTx_q <= 1'b0;
            if (csN) begin
                bitCnt_q <= 5'h0;
                inData_q <= 1'b0;
            end else if (sclkRise) begin
                rxShift_q <= {rxShift_q[14:0], mosi};
                if (!inData_q && bitCnt_q == 5'd7) begin
                    regAddr   <= rxShift_q[6:0];
                    isWrite_q <= mosi;
                    inData_q  <= 1'b1;
                    bitCnt_q  <= 5'h0;
                    loadTx_q  <= ~mosi;
                end else if (inData_q && bitCnt_q == 5'd15) begin
                    bitCnt_q <= 5'h0;
                    if (isWrite_q) begin
                        wrStrobe <= 1'b1;
                        wrData   <= {rxShift_q[14:0], mosi};
                    end else begin
                        loadTx_q <= 1'b1;
                    end
                    if (!noIncrement(regAddr)) begin
                        regAddr <= regAddr + 7'd1;
                    end
                end else begin
                    bitCnt_q <= bitCnt_q + 5'd1;
                end
            end else if (wrStrobe && !noIncrement(regAddr - 7'd1)) begin
                regAddr <= regAddr;
            end
        end
    end

    // A write strobe comes with the address already stepped to the next word, except at the no-increment addresses
    // ------------------------------------------------------------------
    // Transmit on falling edges; word fetched one cycle after its address
    // ------------------------------------------------------------------
    assign rdStrobe = loadTx_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txShift_q <= 16'h0000;
            misoQ_q   <= 1'b0;
        end else if (loadTx_q) begin
            txShift_q <= rdData;
        end else if (sclkFall && inData_q && !isWrite_q) begin
            misoQ_q   <= txShift_q[15];
            txShift_q <= {txShift_q[14:0], 1'b0};
        end
    end

    assign miso   = misoQ_q;
    assign misoOe = ~csN & inData_q & ~isWrite_q;
endmodule
`default_nettype wire
